// >>> core/pcdg_pkg.sv
package pcdg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Printed offsets are not all multiples of four: they are indices, byte address is 4x
    localparam logic [3:0] IDX_PORT_C_LATCH     = 4'h2;
    localparam logic [3:0] IDX_PORT_D_LATCH     = 4'h3;
    localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h6;
    localparam logic [3:0] IDX_PORT_D_DIRECTION = 4'h7;
    localparam logic [3:0] IDX_FUNC_SELECT      = 4'h8;

    localparam int PORT_C_W   = 6;
    localparam int PORT_D_W   = 8;
    localparam int CLKOUT_BIT = 7;
    localparam int CLKOUT_PIN = 2;
    localparam int TA_PIN     = 6;
    localparam int TB_PIN     = 4;
    localparam int ADC_FIRST  = 8;
    localparam int ADC_COUNT  = 7;

    localparam logic [7:0] DIR_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Selection fields live in this block's function select register
    localparam int CH_LSB = 0;
    localparam int CH_W   = 5;
    localparam int PSA_LSB = 8;
    localparam int PSB_LSB = 12;
    localparam int PS_W   = 3;
    localparam logic [2:0] PS_EXT_CLOCK = 3'h7;

    typedef struct packed {
        logic [PORT_D_W-1:0] port_d;
        logic [PORT_C_W-1:0] port_c;
    } pcdg_pins_t;

endpackage

// >>> core/pcdg_port.sv
`timescale 1ns/1ps
// One bit of port pad logic: drive enable and read-back selection
module pcdg_port (
    input  wire logic latch,
    input  wire logic direction,
    input  wire logic pin_sync,
    input  wire logic force_drive,
    input  wire logic force_off,
    input  wire logic analog,
    output logic      drive_en,
    output logic      read_value
);
    always_comb begin
        drive_en = (direction | force_drive) & ~force_off;
        if (direction) begin
            read_value = latch;
        end else if (analog) begin
            read_value = 1'b0;
        end else begin
            read_value = pin_sync;
        end
    end
endmodule

// >>> core/pcdg_sync.sv
`timescale 1ns/1ps
module pcdg_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// >>> core/pcdg_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Six-bit port with read/write data latches
// - Reset leaves six-bit port latches untouched
// - Clock out enable drives clock onto pin 2
// - Clock out overrides pin 2 direction bit
// - Clock out enable read/write, reset clears
// - Port C direction 1 drives, 0 input
// - Reset clears whole port C direction register
// - Port C read: latch if output, else pin
// - Latch writes always land, regardless direction
// - Analog-selected port D input reads zero
// - Timer pins ignore direction for drive
// - Port D bits 6,4 timer external clocks
// - Port D direction 1 drives, 0 input
// - Reset clears all port D direction bits
// - Port D read: latch if output, else pin
// - Port C direction at index 6, bit6 zero
// - Port D direction at index 7; C bits 7,6 zero
module pcdg_top (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [pcdg_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pcdg_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pcdg_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [pcdg_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire pcdg_pkg::pcdg_pins_t          pin_in,
    output pcdg_pkg::pcdg_pins_t               pin_out,
    output pcdg_pkg::pcdg_pins_t               pin_oe_n,
    output logic                               timer_a_ext_clock,
    output logic                               timer_b_ext_clock
);
    localparam int CW = pcdg_pkg::PORT_C_W;
    localparam int DW = pcdg_pkg::PORT_D_W;

    logic [CW-1:0] port_c_latch;
    logic [DW-1:0] port_d_latch;
    logic [CW-1:0] port_c_direction;
    logic          clock_out_enable;
    logic [DW-1:0] port_d_direction;
    logic [pcdg_pkg::CH_W-1:0] adc_channel_select;
    logic [pcdg_pkg::PS_W-1:0] timer_a_prescaler_select;
    logic [pcdg_pkg::PS_W-1:0] timer_b_prescaler_select;

    logic          aw_held;
    logic          w_held;
    logic [3:0]    aw_index;
    logic [7:0]    w_byte;
    logic [pcdg_pkg::DATA_W-1:0] w_word;
    logic          w_lane0;
    logic          w_lane1;

    pcdg_pkg::pcdg_pins_t pin_sync;
    logic [CW-1:0] c_drive;
    logic [CW-1:0] c_read;
    logic [DW-1:0] d_drive;
    logic [DW-1:0] d_read;
    logic [DW-1:0] d_analog;
    logic [DW-1:0] d_timer;
    logic          ta_sel;
    logic          tb_sel;
    logic          clk_phase;

    // Word index sits above the byte offset; anything above the index must be zero
    localparam int IDX_LSB  = 2;
    localparam int IDX_W    = 4;
    localparam int PAGE_LSB = IDX_LSB + IDX_W;

    function automatic logic [IDX_W-1:0] word_index(input logic [pcdg_pkg::ADDR_W-1:0] a);
        word_index = a[IDX_LSB +: IDX_W];
    endfunction

    function automatic logic mapped(input logic [pcdg_pkg::ADDR_W-1:0] a);
        logic [IDX_W-1:0] i;
        i = word_index(a);
        mapped = (a[pcdg_pkg::ADDR_W-1:PAGE_LSB] == '0) &&
                 (i == pcdg_pkg::IDX_PORT_C_LATCH || i == pcdg_pkg::IDX_PORT_D_LATCH ||
                  i == pcdg_pkg::IDX_PORT_C_DIRECTION || i == pcdg_pkg::IDX_PORT_D_DIRECTION ||
                  i == pcdg_pkg::IDX_FUNC_SELECT);
    endfunction

    // One strobed write lane landing on one register index
    function automatic logic hits(input logic             lane,
                                  input logic [IDX_W-1:0] idx,
                                  input logic [IDX_W-1:0] target);
        hits = lane && (idx == target);
    endfunction

    // Write channel: address and data may arrive in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic [pcdg_pkg::ADDR_W-1:0] aw_addr_q;
    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign do_write = (aw_held || aw_take) && (w_held || w_take);

    // A lone address or data beat is parked until its partner arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (do_write) begin
            aw_held   <= 1'b0;
        end else if (aw_take) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    logic [pcdg_pkg::DATA_W-1:0] w_data_q;
    logic [3:0]                  w_strb_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (do_write) begin
            w_held   <= 1'b0;
        end else if (w_take) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    logic [pcdg_pkg::ADDR_W-1:0] wr_addr;
    logic [3:0]                  wr_strb;
    assign wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
    assign w_word   = w_held ? w_data_q : s_axi_wdata;
    assign wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
    assign aw_index = word_index(wr_addr);
    assign w_byte   = w_word[7:0];
    assign w_lane0  = do_write && wr_strb[0] && mapped(wr_addr);
    assign w_lane1  = do_write && wr_strb[1] && mapped(wr_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcdg_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wr_addr) ? pcdg_pkg::RESP_OKAY : pcdg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Data latches carry no reset so their power-up content is kept
    always_ff @(posedge aclk) begin
        if (hits(w_lane0, aw_index, pcdg_pkg::IDX_PORT_C_LATCH)) begin
            port_c_latch <= w_byte[CW-1:0];
        end
        if (hits(w_lane0, aw_index, pcdg_pkg::IDX_PORT_D_LATCH)) begin
            port_d_latch <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_c_direction <= pcdg_pkg::DIR_RESET[CW-1:0];
            clock_out_enable <= pcdg_pkg::DIR_RESET[pcdg_pkg::CLKOUT_BIT];
        end else if (hits(w_lane0, aw_index, pcdg_pkg::IDX_PORT_C_DIRECTION)) begin
            port_c_direction <= w_byte[CW-1:0];
            clock_out_enable <= w_byte[pcdg_pkg::CLKOUT_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_d_direction <= pcdg_pkg::DIR_RESET;
        end else if (hits(w_lane0, aw_index, pcdg_pkg::IDX_PORT_D_DIRECTION)) begin
            port_d_direction <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_channel_select       <= '1;
            timer_a_prescaler_select <= '0;
            timer_b_prescaler_select <= '0;
        end else if (aw_index == pcdg_pkg::IDX_FUNC_SELECT) begin
            if (w_lane0) begin
                adc_channel_select <= w_word[pcdg_pkg::CH_LSB +: pcdg_pkg::CH_W];
            end
            // Lane 1 carries the prescaler fields, so a lane 0 write leaves them alone
            if (w_lane1) begin
                timer_a_prescaler_select <= w_word[pcdg_pkg::PSA_LSB +: pcdg_pkg::PS_W];
                timer_b_prescaler_select <= w_word[pcdg_pkg::PSB_LSB +: pcdg_pkg::PS_W];
            end
        end
    end

    // Pins are resampled before any read or timer use
    pcdg_sync #(.W(CW + DW)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pin_in),
        .q       (pin_sync)
    );

    assign ta_sel = timer_a_prescaler_select == pcdg_pkg::PS_EXT_CLOCK;
    assign tb_sel = timer_b_prescaler_select == pcdg_pkg::PS_EXT_CLOCK;
    assign timer_a_ext_clock = ta_sel & pin_sync.port_d[pcdg_pkg::TA_PIN];
    assign timer_b_ext_clock = tb_sel & pin_sync.port_d[pcdg_pkg::TB_PIN];

    genvar g;
    generate
        for (g = 0; g < CW; g++) begin : g_port_c
            pcdg_port u_bit (
                .latch       (port_c_latch[g]),
                .direction   (port_c_direction[g]),
                .pin_sync    (pin_sync.port_c[g]),
                .force_drive (g == pcdg_pkg::CLKOUT_PIN && clock_out_enable),
                .force_off   (1'b0),
                .analog      (1'b0),
                .drive_en    (c_drive[g]),
                .read_value  (c_read[g])
            );
        end
        // Converter channels count upward from the first port D input
        for (g = 0; g < DW; g++) begin : g_port_d
            assign d_analog[g] = (g < pcdg_pkg::ADC_COUNT) &&
                (adc_channel_select == 5'(pcdg_pkg::ADC_FIRST + g));
            assign d_timer[g] = (g == pcdg_pkg::TA_PIN && ta_sel) ||
                (g == pcdg_pkg::TB_PIN && tb_sel);
            pcdg_port u_bit (
                .latch       (port_d_latch[g]),
                .direction   (port_d_direction[g]),
                .pin_sync    (pin_sync.port_d[g]),
                .force_drive (1'b0),
                .force_off   (d_analog[g] | d_timer[g]),
                .analog      (d_analog[g]),
                .drive_en    (d_drive[g]),
                .read_value  (d_read[g])
            );
        end
    endgenerate

    // Clock out at half the system rate, since a flop cannot forward aclk itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_phase <= 1'b0;
        end else begin
            clk_phase <= ~clk_phase;
        end
    end

    // Pin 2 carries the clock out in place of its latch while enabled
    logic [CW-1:0] c_level;
    always_comb begin
        c_level = port_c_latch;
        if (clock_out_enable) begin
            c_level[pcdg_pkg::CLKOUT_PIN] = clk_phase;
        end
    end

    // Drive values and enables are registered so the pads never see a decode glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
        end else begin
            pin_out.port_c <= c_level;
            pin_out.port_d <= port_d_latch;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe_n <= '1;
        end else begin
            pin_oe_n.port_c <= ~c_drive;
            pin_oe_n.port_d <= ~d_drive;
        end
    end

    // Read channel: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;

    // Select fields sit at fixed positions; the gaps between them read zero
    logic [pcdg_pkg::DATA_W-1:0] sel_word;
    always_comb begin
        sel_word = '0;
        sel_word[pcdg_pkg::CH_LSB +: pcdg_pkg::CH_W]  = adc_channel_select;
        sel_word[pcdg_pkg::PSA_LSB +: pcdg_pkg::PS_W] = timer_a_prescaler_select;
        sel_word[pcdg_pkg::PSB_LSB +: pcdg_pkg::PS_W] = timer_b_prescaler_select;
    end

    logic [7:0] rd_byte;
    logic [3:0] ar_index;
    assign ar_index = word_index(s_axi_araddr);
    always_comb begin
        rd_byte = 8'h00;
        unique case (ar_index)
            pcdg_pkg::IDX_PORT_C_LATCH:     rd_byte = {2'h0, c_read};
            pcdg_pkg::IDX_PORT_D_LATCH:     rd_byte = d_read;
            pcdg_pkg::IDX_PORT_C_DIRECTION: rd_byte = {clock_out_enable, 1'h0, port_c_direction};
            pcdg_pkg::IDX_PORT_D_DIRECTION: rd_byte = port_d_direction;
            default:                        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= pcdg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? pcdg_pkg::RESP_OKAY : pcdg_pkg::RESP_SLVERR;
            // Read data sits in flops, so it stands until the master takes it
            if (ar_index == pcdg_pkg::IDX_FUNC_SELECT) begin
                s_axi_rdata <= sel_word;
            end else begin
                s_axi_rdata <= {24'h0, rd_byte};
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> testbench/pcdg_board.sv
`timescale 1ns/1ps
module pcdg_board (
    input  wire pcdg_pkg::pcdg_pins_t pin_out,
    input  wire pcdg_pkg::pcdg_pins_t pin_oe_n,
    input  wire pcdg_pkg::pcdg_pins_t ext_level,
    output pcdg_pkg::pcdg_pins_t      pin_in
);
    // The board always drives released pads, so an input pad never floats
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

// >>> testbench/pcdg_pins_sva.sv
`timescale 1ns/1ps
module pcdg_pins_sva (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [7:0]           s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic [31:0]          s_axi_wdata,
    input wire logic [3:0]           s_axi_wstrb,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire pcdg_pkg::pcdg_pins_t pin_in,
    input wire pcdg_pkg::pcdg_pins_t pin_out,
    input wire pcdg_pkg::pcdg_pins_t pin_oe_n,
    input wire logic                 timer_a_ext_clock
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wr_hs;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    a_reset_pins_off: assert property ($rose(aresetn) |-> pin_oe_n == '1 && pin_out == '0)
        else $error("pads not released after reset");
    a_b_answer: assert property (wr_hs |=> s_axi_bvalid)
        else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_wr_unmapped: assert property (wr_hs && s_axi_awaddr == 8'h04 |=>
        s_axi_bresp == pcdg_pkg::RESP_SLVERR) else $error("unmapped write not refused");
    // Clock out must win over the pin 2 direction bit, which stays 0 here
    a_clk_out_drive: assert property (wr_hs && s_axi_awaddr == 8'h18 && s_axi_wdata[7]
        && s_axi_wstrb[0] |-> ##[2:4] (!pin_oe_n.port_c[2]
        && pin_out.port_c[2] != $past(pin_out.port_c[2]))) else $error("clock out missing");
    a_timer_a_sync: assert property (timer_a_ext_clock |-> $past(pin_in.port_d[6], 2))
        else $error("timer clock not from synced pad");
endmodule
bind pcdg_top pcdg_pins_sva chk (.*);

// >>> testbench/pcdg_top_tb.sv
`timescale 1ns/1ps
module pcdg_top_tb;
    localparam logic [7:0] A_C = 8'h08, A_D = 8'h0c, A_CD = 8'h18, A_DD = 8'h1c, A_SEL = 8'h20;
    logic                 aclk;
    logic                 aresetn = 1'b0;
    logic [7:0]           s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]           s_axi_wstrb = 4'h0;
    logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic                 s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic                 timer_a_ext_clock, timer_b_ext_clock;
    pcdg_pkg::pcdg_pins_t pin_in, pin_out, pin_oe_n, ext;
    logic [1:0]           bq[$];
    logic [33:0]          rq[$];
    logic [33:0]          rexp;
    int                   miscompares = 0;
    int                   n_checks = 0;
    pcdg_top uut (.*);
    pcdg_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Ready is combinational, so it is judged at the falling edge ahead of the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bq.push_back((a inside {A_C, A_D, A_CD, A_DD, A_SEL}) ? 2'h0 : 2'h2);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(negedge aclk);
        while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(negedge aclk);
        while (!s_axi_bvalid) @(negedge aclk);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back({(a inside {A_C, A_D, A_CD, A_DD, A_SEL}) ? 2'h0 : 2'h2, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        @(posedge aclk);
    endtask
    task automatic pins(input logic [13:0] e, input logic [13:0] o, input logic [13:0] m);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({6'h0, pin_out & m, pin_oe_n}, {6'h0, o & m, e});
        @(posedge aclk);
    endtask
    task automatic tclk(input logic [1:0] e);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk({32'h0, timer_a_ext_clock, timer_b_ext_clock}, {32'h0, e});
        @(posedge aclk);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (11) @(posedge aclk);
        @(negedge aclk);
        chk({6'h0, pin_out, pin_oe_n}, {6'h0, 14'h0, 14'h3fff});
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) begin
            rexp = rq.pop_front();
            chk({s_axi_rresp, rexp[33:32] == 2'h0 ? s_axi_rdata : 32'h0}, rexp);
        end
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] r;
        logic [7:0] q;
        void'($urandom(82750));
        ext <= 14'($urandom);
        do_reset();
        // Latches carry no reset value, so only the enables are judged here
        pins(14'h3fff, 14'h0, 14'h0);
        rd(A_CD, 32'h0);
        rd(A_DD, 32'h0);
        r = 8'($urandom);
        wr(A_C, {24'h0, r}, 4'h1);
        rd(A_C, {26'h0, ext.port_c});
        wr(A_CD, 32'h7f, 4'h1);
        pins(14'h3fc0, {8'h0, r[5:0]}, 14'h003f);
        rd(A_CD, 32'h3f);
        rd(A_C, {26'h0, r[5:0]});
        wr(A_CD, 32'h0, 4'h1);
        q = 8'($urandom);
        wr(A_C, {24'h0, q}, 4'h1);
        rd(A_C, {26'h0, ext.port_c});
        wr(A_CD, 32'h3f, 4'h1);
        rd(A_C, {26'h0, q[5:0]});
        wr(A_CD, 32'h80, 4'h1);
        rd(A_CD, 32'h80);
        pins(14'h3ffb, 14'h0, 14'h0);
        wr(A_CD, 32'h0, 4'h1);
        r = 8'($urandom);
        wr(A_D, {24'h0, r}, 4'h1);
        wr(A_DD, 32'hff, 4'h1);
        pins(14'h003f, {r, 6'h0}, 14'h3fc0);
        rd(A_D, {24'h0, r});
        wr(A_DD, 32'h0, 4'h1);
        // Released pads must pass the two-stage synchroniser first
        repeat (2) @(posedge aclk);
        rd(A_D, {24'h0, ext.port_d});
        for (int g = 0; g < 7; g++) begin
            wr(A_SEL, 32'(8 + g), 4'h1);
            rd(A_D, {24'h0, ext.port_d & ~(8'h1 << g)});
            wr(A_DD, 32'hff, 4'h1);
            rd(A_D, {24'h0, r});
            wr(A_DD, 32'h0, 4'h1);
        end
        // Both prescalers pick their pad as external clock
        wr(A_SEL, 32'h771f, 4'h3);
        wr(A_DD, 32'hff, 4'h1);
        pins(14'h143f, {r, 6'h0}, 14'h2bc0);
        rd(A_D, {24'h0, r});
        ext.port_d[6] <= 1'b1;
        ext.port_d[4] <= 1'b1;
        tclk(2'h3);
        ext.port_d[4] <= 1'b0;
        tclk(2'h2);
        wr(A_SEL, 32'h1f, 4'h3);
        tclk(2'h0);
        wr(8'h04, 32'hff, 4'h1);
        rd(8'h04, 32'h0);
        rd(A_DD, 32'hff);
        wr(A_C, 32'h15, 4'h1);
        do_reset();
        wr(A_CD, 32'h3f, 4'h1);
        rd(A_C, 32'h15);
        tally_and_finish();
    end
endmodule
